// ---- common/card_consts.svh ----
// constants of the serial flash card host controller
`ifndef CARD_CONSTS_SVH
`define CARD_CONSTS_SVH

// ==========================================
// timing
`define SYS_PERIOD_NS 20
`define LINK_PERIOD_NS 160
`define SCLK_HALF_CYC ((`LINK_PERIOD_NS) / (2 * (`SYS_PERIOD_NS)))

// ==========================================
// packet layout
`define BITS_PER_BYTE 8
`define LAST_BIT 3'h7
`define EDGE_RISING 1'h0
`define EDGE_FALLING 1'h1

`endif

// ---- common/card_pkg.sv ----
// types of the serial flash card host controller
package card_pkg;

  // ==========================================
  // link sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_INT = 3'b001,
    ST_TPC = 3'b010,
    ST_DATA = 3'b011,
    ST_HSK = 3'b100
  } link_state_t;

endpackage : card_pkg

// ---- logic/card_host_controller.sv ----
// host end of the three-wire serial flash card link
`timescale 1ns/100ps
`include "card_consts.svh"

module card_host_controller #(
  parameter int HALF_CYC = `SCLK_HALF_CYC,
  parameter int FIFO_DEPTH = 2,
  parameter int WORD_W = 8
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // command
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic [7:0] cmd_tpc_in,
  input wire logic cmd_read_in,
  input wire logic [7:0] cmd_len_in,
  // mode and status
  input wire logic use_two_state_in,
  input wire logic mode_restore_in,
  input wire logic sample_edge_select_in,
  output logic two_state_active_out,
  output logic done_out,
  output logic error_out,
  // write data
  input wire logic tx_valid_in,
  input wire logic [WORD_W-1:0] tx_data_in,
  output logic tx_ready_out,
  // read data
  output logic rx_valid_out,
  output logic [WORD_W-1:0] rx_data_out,
  input wire logic rx_ready_in,
  // card link
  output logic bus_state_line_out,
  output logic serial_clock_out,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe_out
);
  import card_pkg::*;

  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  // ==========================================
  // state
  link_state_t st_reg, st_next;
  logic [7:0] div_reg;
  logic sclk_reg, bs_reg, oe_reg;
  logic [2:0] bit_reg;
  logic [7:0] left_reg, tpc_reg, len_reg;
  logic read_reg, two_reg;
  logic [WORD_W-1:0] tx_sh_reg, rx_sh_reg;
  logic sync1_reg, din_sync;
  logic done_reg, err_reg;
  logic [WORD_W-1:0] mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr;
  logic [CW-1:0] cnt_reg;

  // bus-state level and data drive for a state
  function automatic logic [1:0] drive_of(input link_state_t s, input logic two,
                                          input logic rd);
    case (s)
      ST_INT: drive_of = 2'b00;
      ST_TPC: drive_of = 2'b11;
      ST_DATA: drive_of = {two, ~rd};
      ST_HSK: drive_of = 2'b10;
      default: drive_of = 2'b00;
    endcase
  endfunction : drive_of

  // ==========================================
  // clock divider and edge events
  wire running_w = (st_reg != ST_IDLE);
  wire half_w = (div_reg == 8'(HALF_CYC - 1));
  wire fall_due_w = half_w & sclk_reg;
  wire byte_end_w = (bit_reg == `LAST_BIT);
  wire fifo_full_w = (cnt_reg == CW'(FIFO_DEPTH));
  wire more_w = (left_reg != 8'h01);
  wire need_tx_w = fall_due_w & ~read_reg & byte_end_w &
                   ((st_reg == ST_TPC) | ((st_reg == ST_DATA) & more_w));
  wire need_rx_w = fall_due_w & read_reg & byte_end_w & (st_reg == ST_DATA) & fifo_full_w;
  wire stall_w = (need_tx_w & ~tx_valid_in) | need_rx_w;
  wire tick_w = running_w & half_w & ~stall_w;
  wire rise_w = tick_w & ~sclk_reg;
  wire fall_w = tick_w & sclk_reg;
  wire sample_w = (sample_edge_select_in == `EDGE_FALLING) ? fall_w : rise_w;
  wire recv_w = (st_reg == ST_HSK) | ((st_reg == ST_DATA) & read_reg);
  wire [WORD_W-1:0] rx_byte_w = (sample_edge_select_in == `EDGE_FALLING) ?
                                {rx_sh_reg[WORD_W-2:0], din_sync} : rx_sh_reg;
  wire push_w = fall_w & (st_reg == ST_DATA) & read_reg & byte_end_w;
  wire pop_w = rx_valid_out & rx_ready_in;
  wire ack_w = rx_byte_w[0];
  wire hsk_fail_w = fall_w & (st_reg == ST_HSK) & ~ack_w;
  wire start_w = cmd_valid_in & cmd_ready_out;

  // handshake, link and status outputs
  assign cmd_ready_out = ~running_w;
  assign tx_ready_out = need_tx_w;
  assign rx_valid_out = (cnt_reg != '0);
  assign rx_data_out = mem[rd_ptr];
  assign bus_state_line_out = bs_reg;
  assign serial_clock_out = sclk_reg;
  assign serial_data_line_out = tx_sh_reg[WORD_W-1];
  assign serial_data_line_oe_out = oe_reg;
  assign two_state_active_out = two_reg;
  assign done_out = done_reg;
  assign error_out = err_reg;

  // ==========================================
  // sequencer next state, started by an accepted command, then advanced on falling serial clock edges
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: if (start_w) st_next = ST_INT;
      ST_INT: if (fall_w) st_next = ST_TPC;
      ST_TPC: if (fall_w && byte_end_w) st_next = ST_DATA;
      ST_DATA: begin
        if (fall_w && byte_end_w && !more_w) st_next = two_reg ? ST_IDLE : ST_HSK;
      end
      ST_HSK: if (fall_w) st_next = ack_w ? ST_IDLE : ST_INT;
      default: st_next = ST_IDLE;
    endcase
  end

  // input data synchroniser
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_reg <= 1'h0;
      din_sync <= 1'h0;
    end else begin
      sync1_reg <= serial_data_line_in;
      din_sync <= sync1_reg;
    end
  end

  // clock divider; clock rests low outside a packet
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_reg <= 8'h00;
      sclk_reg <= 1'h0;
    end else if (!running_w || half_w) begin
      div_reg <= 8'h00;
      sclk_reg <= sclk_reg ^ tick_w;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // state, bus-state line and data turnaround on state boundaries
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= ST_IDLE;
      bs_reg <= 1'h0;
      oe_reg <= 1'h0;
    end else begin
      st_reg <= st_next;
      {bs_reg, oe_reg} <= drive_of(st_next, two_reg | hsk_fail_w, read_reg);
    end
  end

  // bit and byte counting, transaction fields
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bit_reg <= 3'h0;
      left_reg <= 8'h00;
      tpc_reg <= 8'h00;
      read_reg <= 1'h0;
      len_reg <= 8'h00;
    end else if (start_w) begin
      bit_reg <= 3'h0;
      left_reg <= (cmd_len_in == 8'h00) ? 8'h01 : cmd_len_in;
      len_reg <= (cmd_len_in == 8'h00) ? 8'h01 : cmd_len_in;
      tpc_reg <= cmd_tpc_in;
      read_reg <= cmd_read_in;
    end else if (fall_w) begin
      bit_reg <= (st_reg == ST_INT || st_reg == ST_HSK) ? 3'h0 : bit_reg + 3'h1;
      if (st_reg == ST_DATA && byte_end_w) left_reg <= left_reg - 8'h01;
      if (hsk_fail_w) left_reg <= len_reg; // replay the whole packet
    end
  end

  // access mode: error forces two-state, set wins over restore
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      two_reg <= 1'h0;
    end else begin
      if (hsk_fail_w) two_reg <= 1'h1;
      else if (start_w) two_reg <= two_reg | use_two_state_in;
      else if (mode_restore_in && !running_w) two_reg <= 1'h0;
    end
  end

  // outgoing shifter: packet code after interrupt state, then write bytes
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_sh_reg <= '0;
    end else if (fall_w) begin
      if (st_reg == ST_INT) tx_sh_reg <= WORD_W'(tpc_reg);
      else if (need_tx_w) tx_sh_reg <= tx_data_in;
      else tx_sh_reg <= {tx_sh_reg[WORD_W-2:0], 1'h0};
    end
  end

  // incoming shifter and completion pulses
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_sh_reg <= '0;
      done_reg <= 1'h0;
      err_reg <= 1'h0;
    end else begin
      if (sample_w && recv_w) rx_sh_reg <= {rx_sh_reg[WORD_W-2:0], din_sync};
      done_reg <= running_w && st_next == ST_IDLE;
      err_reg <= hsk_fail_w;
    end
  end

  // two-entry receive buffer; a full buffer stalls the serial clock
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt_reg <= '0;
    end else begin
      if (push_w) wr_ptr <= (wr_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      if (pop_w) rd_ptr <= (rd_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      cnt_reg <= cnt_reg + CW'(push_w) - CW'(pop_w);
    end
  end

  // buffer storage
  always_ff @(posedge clk_sys_in) begin
    if (push_w) mem[wr_ptr] <= rx_byte_w;
  end

  // ==========================================
  // checks
  property p_idle_quiet;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (st_reg == ST_IDLE && !$past(start_w)) |-> !serial_clock_out && !serial_data_line_oe_out;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("link active while idle");

  property p_int_state;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (st_reg == ST_INT) |-> !bus_state_line_out && !serial_data_line_oe_out;
  endproperty
  a_int_state: assert property (p_int_state) else $error("interrupt state drives");

  property p_tpc_drive;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (st_reg == ST_TPC) |-> bus_state_line_out && serial_data_line_oe_out;
  endproperty
  a_tpc_drive: assert property (p_tpc_drive) else $error("packet code not driven");

  property p_two_no_hsk;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (two_reg && st_reg == ST_DATA) |-> ##1 st_reg != ST_HSK;
  endproperty
  a_two_no_hsk: assert property (p_two_no_hsk) else $error("handshake in two-state");

  property p_hsk_card;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (st_reg == ST_HSK) |-> bus_state_line_out && !serial_data_line_oe_out && !two_reg;
  endproperty
  a_hsk_card: assert property (p_hsk_card) else $error("bad third packet state");

  property p_error_retry;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      hsk_fail_w |=> st_reg == ST_INT && two_reg && error_out ##[1:300] st_reg == ST_TPC;
  endproperty
  a_error_retry: assert property (p_error_retry) else $error("no two-state retry");

  property p_rise_sample;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (rise_w && recv_w && !sample_edge_select_in) |=> rx_sh_reg[0] == $past(din_sync);
  endproperty
  a_rise_sample: assert property (p_rise_sample) else $error("rising capture missed");

  property p_fall_sample;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (rise_w && recv_w && sample_edge_select_in) |=> $stable(rx_sh_reg);
  endproperty
  a_fall_sample: assert property (p_fall_sample) else $error("captured on rising edge");

  property p_sclk_turn;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      $changed(serial_data_line_oe_out) |-> $changed(bus_state_line_out) || $past(fall_w);
  endproperty
  a_sclk_turn: assert property (p_sclk_turn) else $error("turnaround off boundary");

endmodule : card_host_controller

// ---- verification/card_model.sv ----
// behavioural removable card at the far end of the link
`timescale 1ns/100ps
module card_model (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // bench control
  input wire logic host_idle_in,
  input wire logic hs_ok_in,
  input wire logic [7:0] rd_byte_in,
  // link
  input wire logic bus_state_line_in,
  input wire logic serial_clock_in,
  output logic card_data_out
);
  // ==========================================
  // edge detection
  logic sclk_reg, bs_reg;
  logic [1:0] rises_reg;
  logic [2:0] idx_reg;
  wire logic sclk_fall = sclk_reg & ~serial_clock_in;
  wire logic bs_rise = ~bs_reg & bus_state_line_in;
  // card only answers; second state rise is the handshake
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sclk_reg <= 1'b0;
      bs_reg <= 1'b0;
      rises_reg <= 2'h0;
      idx_reg <= 3'h0;
      card_data_out <= 1'b0;
    end else begin
      sclk_reg <= serial_clock_in;
      bs_reg <= bus_state_line_in;
      if (host_idle_in) rises_reg <= 2'h0;
      else if (bs_rise && rises_reg != 2'h3) rises_reg <= rises_reg + 2'h1;
      if (bs_rise) idx_reg <= 3'h1;
      else if (sclk_fall) idx_reg <= idx_reg + 3'h1;
      // data moves just after the clock falls, msb first
      if (bs_rise && rises_reg == 2'h1) card_data_out <= hs_ok_in;
      else if (sclk_fall) card_data_out <= (rises_reg == 2'h2) ? hs_ok_in : rd_byte_in[~idx_reg];
    end
  end
endmodule : card_model

// ---- verification/card_host_controller_tb.sv ----
// self-checking bench of the card host controller
`timescale 1ns/100ps
module card_host_controller_tb;
  logic clk, rstn, cmd_valid, cmd_ready, cmd_read, use_two, restore, edge_sel, two_act;
  logic done, err, tx_valid, tx_ready, rx_valid, rx_ready, bs, sclk, sd_host, oe, card_bit;
  logic hs_ok, sclk_q, oe_q, bs_q, saw_err;
  logic [7:0] cmd_tpc, cmd_len, tx_data, rx_data, rd_byte;
  logic bits[$];
  logic [7:0] rxq[$];
  int fail_count = 0, total_checks = 0, took, bad_turn = 0;
  wire logic sd_line = oe ? sd_host : card_bit;
  // ==========================================
  // design and far side
  card_host_controller dut (.clk_sys_in(clk), .rstn_in(rstn), .cmd_valid_in(cmd_valid),
    .cmd_ready_out(cmd_ready), .cmd_tpc_in(cmd_tpc), .cmd_read_in(cmd_read),
    .cmd_len_in(cmd_len), .use_two_state_in(use_two), .mode_restore_in(restore),
    .sample_edge_select_in(edge_sel), .two_state_active_out(two_act), .done_out(done),
    .error_out(err), .tx_valid_in(tx_valid), .tx_data_in(tx_data), .tx_ready_out(tx_ready),
    .rx_valid_out(rx_valid), .rx_data_out(rx_data), .rx_ready_in(rx_ready),
    .bus_state_line_out(bs), .serial_clock_out(sclk), .serial_data_line_in(sd_line),
    .serial_data_line_out(sd_host), .serial_data_line_oe_out(oe));
  card_model card (.clk_sys_in(clk), .rstn_in(rstn), .host_idle_in(cmd_ready),
    .hs_ok_in(hs_ok), .rd_byte_in(rd_byte), .bus_state_line_in(bs),
    .serial_clock_in(sclk), .card_data_out(card_bit));
  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // collect host bits at clock rise; turnaround only at state change
  always @(posedge clk) begin
    if (sclk && !sclk_q && oe) bits.push_back(sd_host);
    if (oe !== oe_q && !two_act && !use_two && bs === bs_q) bad_turn++;
    sclk_q <= sclk;
    oe_q <= oe;
    bs_q <= bs;
  end
  // ==========================================
  // helpers
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [7:0] byte_at(input int k);
    logic [7:0] b;
    b = 8'hxx;
    if (bits.size() >= k * 8 + 8) for (int i = 0; i < 8; i++) b[7 - i] = bits[k * 8 + i];
    return b;
  endfunction : byte_at
  task automatic run(input logic [7:0] tpc, input logic rd, input logic [7:0] len, input int st);
    int n;
    bits.delete();
    rxq.delete();
    took = 0;
    saw_err = 1'b0;
    cmd_tpc = tpc;
    cmd_read = rd;
    cmd_len = len;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    for (n = 0; n < 20000 && done !== 1'b1; n++) begin
      rx_ready = (n >= st);
      if (rx_valid && rx_ready) rxq.push_back(rx_data);
      if (tx_valid && tx_ready) took++;
      if (err) saw_err = 1'b1;
      @(posedge clk);
      #1;
    end
    rx_ready = 1'b1;
    while (rx_valid === 1'b1) begin
      rxq.push_back(rx_data);
      @(posedge clk);
      #1;
    end
    check(8'(n < 20000), 8'h01);
  endtask : run
  task automatic restore_mode;
    restore = 1'b1;
    @(posedge clk);
    #1 restore = 1'b0;
    check({7'h0, two_act}, 8'h00);
  endtask : restore_mode
  // ==========================================
  // scenarios
  task automatic t_write;
    run(8'h2d, 1'b0, 8'h00, 0); // zero length counts as one byte
    check(byte_at(0), 8'h2d);
    check(byte_at(1), 8'ha5);
    check({7'h0, saw_err}, 8'h00);
    check({7'h0, two_act}, 8'h00);
    $display("write test ended");
  endtask : t_write
  task automatic t_read(input logic e, input logic [7:0] pat);
    edge_sel = e;
    rd_byte = pat;
    run(8'h4b, 1'b1, 8'h03, 400);
    check(8'(rxq.size()), 8'h03);
    foreach (rxq[i]) check(rxq[i], pat);
    check(8'(bits.size()), 8'h08);
    $display("read test ended");
  endtask : t_read
  task automatic t_error;
    hs_ok = 1'b0;
    run(8'h1e, 1'b0, 8'h01, 0);
    check({7'h0, saw_err}, 8'h01);
    check({7'h0, two_act}, 8'h01);
    check(8'(took), 8'h02);
    check(byte_at(2), 8'h1e);
    hs_ok = 1'b1;
    restore_mode();
    $display("error retry test ended");
  endtask : t_error
  task automatic t_two;
    use_two = 1'b1;
    hs_ok = 1'b0;
    rd_byte = 8'h5a;
    run(8'h87, 1'b1, 8'h01, 0);
    check({7'h0, saw_err}, 8'h00);
    check(rxq[0], 8'h5a);
    use_two = 1'b0;
    hs_ok = 1'b1;
    restore_mode();
    $display("two-state test ended");
  endtask : t_two
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // ==========================================
  // main sequence and watchdog
  initial begin
    {rstn, cmd_valid, cmd_read, use_two, restore, edge_sel, rx_ready} = 7'h0;
    cmd_tpc = 8'h00;
    cmd_len = 8'h00;
    tx_valid = 1'b1;
    tx_data = 8'ha5;
    hs_ok = 1'b1;
    rd_byte = 8'h00;
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    t_write();
    t_read(1'b0, 8'hc6);
    t_read(1'b1, 8'h39);
    t_error();
    t_two();
    check(8'(bad_turn), 8'h00);
    stop_test();
  end
  initial begin
    #400000;
    fail_count++;
    stop_test();
  end
endmodule : card_host_controller_tb
